// file: src/ash_state_handshake.sv
// application layer state handshake registers and indicator overrides
// assumes both access ports are byte wide and synchronous to i_sys_clk
//
// Overview of operation
// - request low nibble holds requested state, reset 1
// - request bit 4 acknowledges error indication
// - request bit 5 asks for device identification
// - without emulation, network writes lock the request
// - request register is open after reset
// - host access to either byte unlocks
// - with emulation, network write copied into status
// - write-ack mode: host write clears event bit
// - otherwise host read clears event bit
// - status low nibble reports actual state, reset 1
// - status bit 4 is the error indication
// - status bit 5 shows identification loaded
// - host writes status only without emulation
// - network status read clears network event bit
// - diagnostic code: host read-write, network read
// - run indicator codes follow the state table
// - override bit 4 enables, reserved bits zero
// - valid status change clears run override enable
// - override readback shows the current indicator code
// - fault indicator codes and enable bit 4
// - new error clears fault override enable
`timescale 1ns/1ps
module ash_state_handshake
    import ash_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // byte access ports
    input wire ash_bus_t i_net,
    input wire ash_bus_t i_host,
    // configuration
    input wire logic i_emulation,
    input wire logic i_wr_ack_mode,
    // fault indicator inputs
    input wire logic i_new_error,
    input wire logic [3:0] i_fault_auto_code,
    // read answers
    output logic [7:0] o_net_rdata,
    output logic o_net_rvalid,
    output logic [7:0] o_host_rdata,
    output logic o_host_rvalid,
    // event request clears, one-cycle pulses
    output logic o_app_event_clr,
    output logic o_net_event_clr,
    // register state
    output logic o_req_locked,
    output logic [5:0] o_state_request,
    output logic [5:0] o_state_report,
    // indicator codes
    output logic [3:0] o_run_code,
    output logic [3:0] o_fault_code
);

    // ****************************************
    // storage
    // ****************************************
    logic [5:0] req;       // requested state, ack, identification request
    logic [5:0] stat;      // actual state, error indication, id loaded
    logic [15:0] diag;     // diagnostic status code
    logic [5:0] next_req;
    logic [5:0] next_stat;
    logic [15:0] next_diag;
    logic net_accept;      // lock lets a network write through
    logic run_en;
    logic fault_en;
    logic [3:0] run_shown;
    logic [3:0] fault_shown;
    logic [7:0] run_read;
    logic [7:0] fault_read;
    ash_regs_t regs;       // read images for the mux

    // ****************************************
    // address decode
    // ****************************************
    wire net_at_req = (i_net.addr == ADDR_REQ_LO) || (i_net.addr == ADDR_REQ_HI);
    wire net_at_stat = (i_net.addr == ADDR_STAT_LO) || (i_net.addr == ADDR_STAT_HI);
    wire host_at_req = (i_host.addr == ADDR_REQ_LO) || (i_host.addr == ADDR_REQ_HI);
    wire net_req_wr = i_net.wr && net_at_req;
    wire net_req_ok = net_req_wr && net_accept;
    wire net_req_lo_ok = net_req_ok && (i_net.addr == ADDR_REQ_LO);
    wire host_req_access = (i_host.wr || i_host.rd) && host_at_req;
    // status writable by host only while emulation is off
    wire host_stat_lo_wr = i_host.wr && !i_emulation && (i_host.addr == ADDR_STAT_LO);
    wire host_diag_lo_wr = i_host.wr && (i_host.addr == ADDR_DIAG_LO);
    wire host_diag_hi_wr = i_host.wr && (i_host.addr == ADDR_DIAG_HI);
    wire net_run_wr = i_net.wr && (i_net.addr == ADDR_RUN);
    wire host_run_wr = i_host.wr && (i_host.addr == ADDR_RUN);
    wire net_fault_wr = i_net.wr && (i_net.addr == ADDR_FAULT);
    wire host_fault_wr = i_host.wr && (i_host.addr == ADDR_FAULT);

    // ****************************************
    // override write merge, network first on a tie
    // ****************************************
    wire run_wr = net_run_wr || host_run_wr;
    wire [7:0] run_wdata = net_run_wr ? i_net.wdata : i_host.wdata;
    wire fault_wr = net_fault_wr || host_fault_wr;
    wire [7:0] fault_wdata = net_fault_wr ? i_net.wdata : i_host.wdata;

    // ****************************************
    // hardware side effects
    // ****************************************
    // a status change to a defined state code drops the run override
    wire run_clear = (next_stat[STATE_MSB:0] != stat[STATE_MSB:0]) &&
        is_valid_state(next_stat[STATE_MSB:0]);
    // new error: external event or the error indication rising
    wire fault_clear = i_new_error || (next_stat[ERR_BIT] && !stat[ERR_BIT]);
    // event clear by host write or by host read, per acknowledge mode
    wire next_app_clr = host_req_access && (i_wr_ack_mode ? i_host.wr : i_host.rd);
    // network reading status clears its event bit
    wire next_net_clr = i_net.rd && net_at_stat;
    // normal run pattern derived from the actual state
    wire [3:0] run_auto = state_to_run_code(stat[STATE_MSB:0]);

    // ****************************************
    // next values
    // ****************************************
    // request: network low-byte write only; host writes never store
    always_comb begin
        next_req = req;
        if (net_req_lo_ok) begin
            next_req = i_net.wdata[5:0];
        end
    end

    // status: emulation copy of request, else host write
    always_comb begin
        next_stat = stat;
        if (i_emulation) begin
            if (net_req_lo_ok) begin
                next_stat = i_net.wdata[5:0];
            end
        end else if (host_stat_lo_wr) begin
            next_stat = i_host.wdata[5:0];
        end
    end

    // diagnostic code: host writes either byte
    always_comb begin
        next_diag = diag;
        if (host_diag_lo_wr) begin
            next_diag[7:0] = i_host.wdata;
        end
        if (host_diag_hi_wr) begin
            next_diag[15:8] = i_host.wdata;
        end
    end

    // ****************************************
    // register flops
    // ****************************************
    // handshake registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req <= REQ_RESET;
            stat <= STAT_RESET;
            diag <= DIAG_RESET;
        end else begin
            req <= next_req;
            stat <= next_stat;
            diag <= next_diag;
        end
    end

    // event pulses and visible copies
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_app_event_clr <= 1'b0;
            o_net_event_clr <= 1'b0;
            o_state_request <= REQ_RESET;
            o_state_report <= STAT_RESET;
            o_run_code <= LED_OFF;
            o_fault_code <= LED_OFF;
        end else begin
            o_app_event_clr <= next_app_clr;
            o_net_event_clr <= next_net_clr;
            o_state_request <= next_req;
            o_state_report <= next_stat;
            o_run_code <= run_shown;
            o_fault_code <= fault_shown;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    assign regs = '{req: req, stat: stat, diag: diag, run: run_read, fault: fault_read};

    // read data one cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_net_rdata <= 8'h00;
            o_net_rvalid <= 1'b0;
            o_host_rdata <= 8'h00;
            o_host_rvalid <= 1'b0;
        end else begin
            o_net_rvalid <= i_net.rd;
            o_host_rvalid <= i_host.rd;
            if (i_net.rd) begin
                o_net_rdata <= read_byte(i_net.addr, regs);
            end
            if (i_host.rd) begin
                o_host_rdata <= read_byte(i_host.addr, regs);
            end
        end
    end

    // ****************************************
    // submodules
    // ****************************************
    // request mailbox lock
    ash_mailbox_lock u_lock (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_net_wr(net_req_wr),
        .i_host_access(host_req_access),
        .i_emulation(i_emulation),
        .o_accept(net_accept),
        .o_locked(o_req_locked)
    );

    // run indicator override
    ash_indicator_override u_run (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_wr(run_wr),
        .i_wdata(run_wdata),
        .i_hw_clear(run_clear),
        .i_auto_code(run_auto),
        .o_enable(run_en),
        .o_shown_code(run_shown),
        .o_read_value(run_read)
    );

    // fault indicator override
    ash_indicator_override u_fault (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_wr(fault_wr),
        .i_wdata(fault_wdata),
        .i_hw_clear(fault_clear),
        .i_auto_code(i_fault_auto_code),
        .o_enable(fault_en),
        .o_shown_code(fault_shown),
        .o_read_value(fault_read)
    );

    // ****************************************
    // assertions
    // ****************************************
    lock_blocks_write_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_req_locked && !i_emulation && i_net.wr && (i_net.addr == ADDR_REQ_LO)
        |=> $stable(req))
        else $error("locked request changed on network write");

    lock_release_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        host_req_access && !net_req_wr |=> !o_req_locked)
        else $error("host access did not release lock");

    emul_copy_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_emulation && i_net.wr && (i_net.addr == ADDR_REQ_LO)
        |=> (stat == $past(i_net.wdata[5:0])) && (req == stat))
        else $error("emulation copy missing");

    stat_guard_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_emulation && !net_req_lo_ok |=> $stable(stat))
        else $error("status changed under emulation without request write");

    host_req_write_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_wr_ack_mode && i_host.wr && host_at_req && !net_req_wr
        |=> o_app_event_clr && $stable(req))
        else $error("ack-mode host write misbehaved");

    host_req_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_wr_ack_mode && host_at_req |=> o_app_event_clr == $past(i_host.rd))
        else $error("host read event clear wrong");

    net_stat_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_net.rd && net_at_stat |=> o_net_event_clr ##1 !o_net_event_clr || $past(next_net_clr))
        else $error("network event clear pulse missing");

    diag_write_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        host_diag_lo_wr |=> diag[7:0] == $past(i_host.wdata))
        else $error("diagnostic low byte not written");

    run_clear_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        run_clear |=> !run_en ##1 o_run_code == $past(run_auto))
        else $error("run override not cleared");

    fault_clear_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_new_error |=> !fault_en)
        else $error("fault override not cleared");

    shown_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_net.rd && (i_net.addr == ADDR_RUN) |=> o_net_rdata == {3'h0, $past(run_en),
        $past(run_shown)})
        else $error("run readback is not the shown code");

    diag_high_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        host_diag_hi_wr |=> diag[15:8] == $past(i_host.wdata))
        else $error("diag high byte lost");

    run_write_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        run_wr && !run_clear |=> run_en == $past(run_wdata[OVR_EN_BIT]))
        else $error("run enable not written");

    ack_no_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_wr_ack_mode && !i_host.wr |=> !o_app_event_clr)
        else $error("event cleared without write");

    net_stat_ro_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_net.wr && net_at_stat && !i_host.wr && !i_emulation |=> $stable(stat))
        else $error("network wrote status");

    lock_set_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        net_req_ok && !i_emulation |=> o_req_locked)
        else $error("accepted write left lock open");

endmodule

// file: src/ash_pkg.sv
// state handshake package: register map, field layout, reset values, codes
// assumes byte-wide register accesses from both the network side and the host
package ash_pkg;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [15:0] ADDR_REQ_LO = 16'h0120;
    localparam logic [15:0] ADDR_REQ_HI = 16'h0121;
    localparam logic [15:0] ADDR_STAT_LO = 16'h0130;
    localparam logic [15:0] ADDR_STAT_HI = 16'h0131;
    localparam logic [15:0] ADDR_DIAG_LO = 16'h0134;
    localparam logic [15:0] ADDR_DIAG_HI = 16'h0135;
    localparam logic [15:0] ADDR_RUN = 16'h0138;
    localparam logic [15:0] ADDR_FAULT = 16'h0139;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int STATE_MSB = 3;
    localparam int ERR_BIT = 4;
    localparam int ID_BIT = 5;
    localparam int OVR_EN_BIT = 4;
    localparam logic [5:0] REQ_RESET = 6'h01;
    localparam logic [5:0] STAT_RESET = 6'h01;
    localparam logic [15:0] DIAG_RESET = 16'h0000;
    localparam logic [7:0] OVR_RESET = 8'h00;

    // ****************************************
    // state and indicator codes
    // ****************************************
    localparam logic [3:0] ST_INIT = 4'h1;
    localparam logic [3:0] ST_PREOPERATIONAL_STATE = 4'h2;
    localparam logic [3:0] ST_BOOT = 4'h3;
    localparam logic [3:0] ST_SAFE_OPERATIONAL_STATE = 4'h4;
    localparam logic [3:0] ST_OP = 4'h8;
    localparam logic [3:0] LED_OFF = 4'h0;
    localparam logic [3:0] LED_FLASH1 = 4'h1;
    localparam logic [3:0] LED_BLINK = 4'hD;
    localparam logic [3:0] LED_FLICKER = 4'hE;
    localparam logic [3:0] LED_ON = 4'hF;

    // one byte access: address, write and read strobes, write data
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } ash_bus_t;

    // images of the readable registers
    typedef struct packed {
        logic [5:0] req;
        logic [5:0] stat;
        logic [15:0] diag;
        logic [7:0] run;
        logic [7:0] fault;
    } ash_regs_t;

    // true for the five defined state codes
    function automatic logic is_valid_state(input logic [3:0] code);
        return (code == ST_INIT) || (code == ST_PREOPERATIONAL_STATE) || (code == ST_BOOT) ||
            (code == ST_SAFE_OPERATIONAL_STATE) || (code == ST_OP);
    endfunction

    // run indicator pattern that belongs to an actual state
    function automatic logic [3:0] state_to_run_code(input logic [3:0] code);
        case (code)
            ST_SAFE_OPERATIONAL_STATE: return LED_FLASH1;
            ST_PREOPERATIONAL_STATE: return LED_BLINK;
            ST_BOOT: return LED_FLICKER;
            ST_OP: return LED_ON;
            default: return LED_OFF;
        endcase
    endfunction

    // byte read mux shared by both access ports, reserved bits zero
    function automatic logic [7:0] read_byte(input logic [15:0] addr, input ash_regs_t r);
        case (addr)
            ADDR_REQ_LO: return {2'h0, r.req};
            ADDR_STAT_LO: return {2'h0, r.stat};
            ADDR_DIAG_LO: return r.diag[7:0];
            ADDR_DIAG_HI: return r.diag[15:8];
            ADDR_RUN: return r.run;
            ADDR_FAULT: return r.fault;
            default: return 8'h00;
        endcase
    endfunction

endpackage

// file: src/ash_mailbox_lock.sv
// mailbox lock of the state request register
// assumes strobes from logic on the same clock, one cycle each
`timescale 1ns/1ps
module ash_mailbox_lock
    import ash_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // events
    input wire logic i_net_wr,      // network write to the request register
    input wire logic i_host_access, // host read or write of either byte
    input wire logic i_emulation,   // device emulation on
    // lock state
    output logic o_accept,          // network write would be taken now
    output logic o_locked
);

    logic next_locked;

    // emulation bypasses the lock entirely
    assign o_accept = i_emulation || !o_locked;

    // a taken write locks, host access unlocks; lock wins on a tie
    always_comb begin
        next_locked = o_locked;
        if (i_net_wr && o_accept && !i_emulation) begin
            next_locked = 1'b1;
        end else if (i_host_access) begin
            next_locked = 1'b0;
        end
    end

    // lock flop, open after reset
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_locked <= 1'b0;
        end else begin
            o_locked <= next_locked;
        end
    end

endmodule

// file: src/ash_indicator_override.sv
// one indicator override register: code, enable, shown-code readback
// assumes a single merged write strobe from both access sides
`timescale 1ns/1ps
module ash_indicator_override
    import ash_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // register access
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    // hardware clear of the enable and normal pattern
    input wire logic i_hw_clear,
    input wire logic [3:0] i_auto_code,
    // state
    output logic o_enable,
    output logic [3:0] o_shown_code,
    output logic [7:0] o_read_value
);

    logic [3:0] code;

    // shown code: override code when enabled, else the normal pattern
    assign o_shown_code = o_enable ? code : i_auto_code;
    // readback gives the shown code, reserved bits zero
    assign o_read_value = {3'h0, o_enable, o_shown_code};

    // code and enable; the hardware clear beats a same-cycle write
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            code <= OVR_RESET[3:0];
            o_enable <= OVR_RESET[OVR_EN_BIT];
        end else begin
            if (i_wr) begin
                code <= i_wdata[3:0];
            end
            if (i_hw_clear) begin
                o_enable <= 1'b0;
            end else if (i_wr) begin
                o_enable <= i_wdata[OVR_EN_BIT];
            end
        end
    end

endmodule

// file: verification/ash_bus_agent.sv
// byte access master model for one port of the state handshake block
// assumes the block answers a read with rvalid one clock after the strobe
`timescale 1ns/1ps
module ash_bus_agent
    import ash_pkg::*;
(
    // clock
    input wire logic i_sys_clk,
    // read answer from the block
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    // access request to the block
    output ash_bus_t o_bus
);
    // ****************************************
    // idle and access tasks
    // ****************************************
    // strobes low from time zero
    initial begin
        o_bus = '0;
    end

    // one write strobe, held until the taking edge, then released
    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge i_sys_clk);
        #1;
        o_bus = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
        @(posedge i_sys_clk);
        #1;
        // released fields scrambled so stale values are never relied on
        o_bus = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~data};
    endtask

    // one read strobe; answer sampled just after the following edge
    task automatic rd(input logic [15:0] addr, output logic [7:0] data, output logic ok);
        @(posedge i_sys_clk);
        #1;
        o_bus = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge i_sys_clk);
        #1;
        ok = i_rvalid;
        data = i_rdata;
        o_bus = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: 8'h5a};
    endtask
endmodule

// file: verification/ash_state_handshake_tb.sv
// self-checking bench of the state handshake register block
// assumes the byte access masters of ash_bus_agent.sv on both ports
`timescale 1ns/1ps
module ash_state_handshake_tb
    import ash_pkg::*;
;
    // ****************************************
    // signals and model state
    // ****************************************
    logic i_sys_clk, i_rst_n, emu, ack_mode, new_err;
    logic [3:0] flt_auto, run_code, flt_code;
    ash_bus_t net_bus, host_bus;
    logic [7:0] net_rdata, host_rdata, rd_val;
    logic net_rvalid, host_rvalid, app_clr, net_clr, locked;
    logic [5:0] st_req, st_rep;
    logic [15:0] dv;
    int fail_count, n_checks, cycles, seed, app_n, net_n, m_app, m_net;
    int m_req, m_stat, m_diag, m_run, m_flt, m_lock;
    int codes[5] = '{1, 3, 2, 4, 8};
    logic [15:0] addrs[9] = '{16'h0120, 16'h0121, 16'h0130, 16'h0131, 16'h0134,
        16'h0135, 16'h0138, 16'h0139, 16'h0200};

    ash_state_handshake u_ash_state_handshake (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_net(net_bus), .i_host(host_bus), .i_emulation(emu), .i_wr_ack_mode(ack_mode),
        .i_new_error(new_err), .i_fault_auto_code(flt_auto), .o_net_rdata(net_rdata),
        .o_net_rvalid(net_rvalid), .o_host_rdata(host_rdata), .o_host_rvalid(host_rvalid),
        .o_app_event_clr(app_clr), .o_net_event_clr(net_clr), .o_req_locked(locked),
        .o_state_request(st_req), .o_state_report(st_rep), .o_run_code(run_code),
        .o_fault_code(flt_code));
    ash_bus_agent u_ash_bus_agent_net (.i_sys_clk(i_sys_clk), .i_rdata(net_rdata),
        .i_rvalid(net_rvalid), .o_bus(net_bus));
    ash_bus_agent u_ash_bus_agent_host (.i_sys_clk(i_sys_clk), .i_rdata(host_rdata),
        .i_rvalid(host_rvalid), .o_bus(host_bus));

    // ****************************************
    // clock, event counting, timeout
    // ****************************************
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    // counts clear pulses; cuts a hang short
    always @(posedge i_sys_clk) begin
        cycles++;
        if (app_clr === 1'b1) app_n++;
        if (net_clr === 1'b1) net_n++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ****************************************
    // reference model
    // ****************************************
    // readback of an override register: enable and code, else normal pattern
    function automatic int ovr_rd(int r, int auto_c);
        return (r & 16) ? (r & 31) : auto_c;
    endfunction

    // normal run pattern for a state
    function automatic int run_auto(int s);
        case (s & 15)
            4: return 1;
            2: return 13;
            3: return 14;
            8: return 15;
            default: return 0;
        endcase
    endfunction

    // expected read byte, reserved bits zero
    function automatic int exp_rd(int a);
        case (a)
            16'h0120: return m_req;
            16'h0130: return m_stat;
            16'h0134: return m_diag & 255;
            16'h0135: return m_diag >> 8;
            16'h0138: return ovr_rd(m_run, run_auto(m_stat));
            16'h0139: return ovr_rd(m_flt, int'(flt_auto));
            default: return 0;
        endcase
    endfunction

    // status update with its side effects on the override enables
    function automatic void set_stat(int v);
        if ((v & 15) != (m_stat & 15) && (v & 15) inside {1, 2, 3, 4, 8}) m_run &= 15;
        if ((v & 16) && !(m_stat & 16)) m_flt &= 15;
        m_stat = v;
    endfunction

    // ****************************************
    // checking and access tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    // compares the register state outputs one cycle after an access
    task automatic cmp_state();
        @(posedge i_sys_clk);
        #1;
        if (!emu) chk({7'h00, locked}, 8'(m_lock));
        chk({2'b00, st_req}, 8'(m_req));
        chk({2'b00, st_rep}, 8'(m_stat));
        chk({4'h0, run_code}, 8'(ovr_rd(m_run, run_auto(m_stat)) & 15));
        chk({4'h0, flt_code}, 8'(ovr_rd(m_flt, int'(flt_auto)) & 15));
    endtask

    // host reads keep off status
    task automatic rd(input bit net, input logic [15:0] a);
        logic ok;
        if (net) u_ash_bus_agent_net.rd(a, rd_val, ok);
        else u_ash_bus_agent_host.rd(a, rd_val, ok);
        chk({7'h00, ok}, 8'h01);
        chk(rd_val, 8'(exp_rd(a)));
        if (net && a[15:1] == 15'h0098) m_net++;
        if (!net && a[15:1] == 15'h0090) begin
            m_lock = 0;
            if (!ack_mode) m_app++;
        end
    endtask

    task automatic wr(input bit net, input logic [15:0] a, input logic [7:0] d);
        flt_auto = 4'($random(seed));
        if (net) u_ash_bus_agent_net.wr(a, d);
        else u_ash_bus_agent_host.wr(a, d);
        if (a[15:1] == 15'h0090 && !net) begin
            m_lock = 0;
            if (ack_mode) m_app++;
        end else if (a[15:1] == 15'h0090 && (emu || !m_lock)) begin
            if (!a[0]) m_req = d & 63;
            if (!a[0] && emu) set_stat(d & 63);
            if (!emu) m_lock = 1;
        end
        if (a == 16'h0130 && !net && !emu) set_stat(d & 63);
        if (a[15:1] == 15'h009a && !net) m_diag = a[0] ? (m_diag & 255) | (d << 8) :
            (m_diag & 16'hff00) | d;
        if (a == 16'h0138) m_run = d & 31;
        if (a == 16'h0139) m_flt = d & 31;
        cmp_state();
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 32'h20b6_f83c;
        {i_rst_n, emu, ack_mode, new_err, flt_auto} = '0;
        m_req = 1;
        m_stat = 1;
        repeat (3) @(posedge i_sys_clk);
        #1 i_rst_n = 1'b1;
        // reset values seen from the network side
        foreach (addrs[i]) rd(1, addrs[i]);
        // mailbox handshake without emulation
        wr(1, 16'h0120, 8'h02);
        wr(1, 16'h0120, 8'h04);
        wr(1, 16'h0121, 8'h00);
        rd(0, 16'h0120);
        wr(1, 16'h0120, 8'h14);
        ack_mode = 1'b1;
        wr(0, 16'h0120, 8'h00);
        wr(1, 16'h0120, 8'h28);
        rd(0, 16'h0121);
        wr(1, 16'h0120, 8'hc1);
        rd(0, 16'h0200);
        // host-set status and override clearing
        wr(1, 16'h0138, 8'h1a);
        wr(0, 16'h0139, 8'(16 | ($random(seed) & 15)));
        wr(0, 16'h0130, 8'hf2);
        rd(1, 16'h0130);
        wr(1, 16'h0130, 8'h08);
        wr(0, 16'h0139, 8'h1f);
        @(posedge i_sys_clk);
        #1 new_err = 1'b1;
        @(posedge i_sys_clk);
        #1 new_err = 1'b0;
        m_flt &= 15;
        cmp_state();
        wr(1, 16'h0139, 8'hff);
        rd(0, 16'h0139);
        // emulation copies every state code into the status
        emu = 1'b1;
        foreach (codes[i]) begin
            wr(0, 16'h0138, 8'(16 | ($random(seed) & 15)));
            wr(1, 16'h0120, 8'(codes[i] | (($random(seed) & 1) << 5)));
            wr(0, 16'h0130, 8'h08);
            rd(1, 16'h0138);
            rd(1, 16'h0130);
        end
        // diagnostic code: host writes, network reads only
        repeat (3) begin
            dv = 16'($random(seed));
            wr(0, 16'h0134, dv[7:0]);
            wr(0, 16'h0135, dv[15:8]);
            wr(1, 16'h0134, ~dv[7:0]);
            rd(1, 16'h0134);
            rd(1, 16'h0135);
            rd(0, 16'h0135);
        end
        repeat (2) @(posedge i_sys_clk);
        chk(8'(app_n), 8'(m_app));
        chk(8'(net_n), 8'(m_net));
        wrap_up();
    end
endmodule
